// >>> verilog/drawing_engine_command_regs.sv
// Command and status register bank of the 2D drawing engine, reached over APB.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module drawing_engine_command_regs
   import draw_regs_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Engine side events and state
   input wire logic vsync_event,
   input wire logic engine_busy,
   input wire logic command_taken,
   input wire logic eight_planes,
   // Controls toward the engine
   output logic irq_request,
   output logic [1:0] soft_reset_sel,
   output logic [15:0] advanced_function,
   output logic [11:0] current_y,
   output logic [11:0] current_x,
   output logic [13:0] dest_y_step,
   output logic [13:0] dest_x_step,
   output logic [13:0] line_error,
   output logic [11:0] major_axis,
   output draw_command_t draw_command,
   output logic draw_command_valid,
   output short_vector_t vector_first,
   output short_vector_t vector_second,
   output logic vector_valid,
   output logic [31:0] background_colour,
   output logic [31:0] foreground_colour,
   output logic [31:0] plane_write_mask,
   output logic [31:0] plane_read_mask,
   output logic [31:0] compare_colour,
   output mix_select_t background_mix,
   output mix_select_t foreground_mix
);

   logic enhanced_access_q;
   logic [irq_count-1:0] irq_flags_q;
   logic [irq_count-1:0] irq_enable_q;
   logic [3:0] queue_level_q;
   logic busy_prev_q;
   logic [31:0] rdata_d;
   logic hit;
   logic setup;
   logic wr;
   logic rd;
   logic cfg_hit;
   logic bank_hit;
   logic [irq_count-1:0] irq_set;
   logic [irq_count-1:0] irq_clear;
   logic cmd_write;
   logic queue_full;
   logic queue_push;
   logic queue_pop;
   logic [12:0] free_slots;
   // One write strobe per plain storage register keeps each register in a process of its own.
   logic wr_advanced_function;
   logic wr_current_y;
   logic wr_current_x;
   logic wr_dest_y_step;
   logic wr_dest_x_step;
   logic wr_line_error;
   logic wr_major_axis;
   logic wr_background_colour;
   logic wr_foreground_colour;
   logic wr_plane_write_mask;
   logic wr_plane_read_mask;
   logic wr_compare_colour;
   logic wr_background_mix;
   logic wr_foreground_mix;

   // Accesses complete in the cycle after setup, so pready rises with penable.
   assign setup = psel && !penable;
   assign cfg_hit = (paddr == system_config_addr);

   always_comb begin
      bank_hit = 1'b0;
      unique case (paddr)
         subsystem_addr, advanced_function_addr, current_y_addr, current_x_addr, dest_y_step_addr,
         dest_x_step_addr, line_error_addr, major_axis_addr, engine_cmd_addr, short_vector_addr,
         background_colour_addr, foreground_colour_addr, plane_write_mask_addr, plane_read_mask_addr,
         compare_colour_addr, background_mix_addr, foreground_mix_addr: bank_hit = 1'b1;
         default: bank_hit = 1'b0;
      endcase
   end

   // The bank answers only with enhanced access on; otherwise it is an unmapped address.
   assign hit = cfg_hit || (bank_hit && enhanced_access_q);
   assign wr = psel && penable && pready && pwrite && hit;
   assign rd = psel && penable && pready && !pwrite && hit;

   assign cmd_write = wr && (paddr == engine_cmd_addr);
   assign queue_full = (queue_level_q == queue_depth[3:0]);
   assign queue_push = cmd_write && !queue_full;
   assign queue_pop = command_taken && (queue_level_q != 4'h0);
   assign free_slots = queue_depth_slots - {9'h000, queue_level_q};

   // Write strobes; each already carries the access gate of the bank, so a closed bank stores nothing.
   assign wr_advanced_function = wr && (paddr == advanced_function_addr);
   assign wr_current_y = wr && (paddr == current_y_addr);
   assign wr_current_x = wr && (paddr == current_x_addr);
   assign wr_dest_y_step = wr && (paddr == dest_y_step_addr);
   assign wr_dest_x_step = wr && (paddr == dest_x_step_addr);
   assign wr_line_error = wr && (paddr == line_error_addr);
   assign wr_major_axis = wr && (paddr == major_axis_addr);
   assign wr_background_colour = wr && (paddr == background_colour_addr);
   assign wr_foreground_colour = wr && (paddr == foreground_colour_addr);
   assign wr_plane_write_mask = wr && (paddr == plane_write_mask_addr);
   assign wr_plane_read_mask = wr && (paddr == plane_read_mask_addr);
   assign wr_compare_colour = wr && (paddr == compare_colour_addr);
   assign wr_background_mix = wr && (paddr == background_mix_addr);
   assign wr_foreground_mix = wr && (paddr == foreground_mix_addr);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= setup;
         pslverr <= setup && !hit;
         prdata <= (setup && !pwrite && hit) ? rdata_d : 32'h0000_0000;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enhanced_access_q <= 1'b0;
      end else if (wr && cfg_hit) begin
         enhanced_access_q <= pwdata[0];
      end
   end

   // Event detection for the interrupt sources.
   always_comb begin
      irq_set = '0;
      irq_set[irq_vsync] = vsync_event;
      irq_set[irq_busy] = engine_busy && !busy_prev_q;
      irq_set[irq_overflow] = cmd_write && queue_full;
      irq_set[irq_empty] = queue_pop && (queue_level_q == 4'h1) && !queue_push;
      irq_clear = (wr && paddr == subsystem_addr) ? pwdata[irq_count-1:0] : '0;
   end

   // A new event in the clearing cycle wins over the clear.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_flags_q <= '0;
         busy_prev_q <= 1'b0;
      end else begin
         irq_flags_q <= (irq_flags_q & ~irq_clear) | irq_set;
         busy_prev_q <= engine_busy;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_q <= '0;
         soft_reset_sel <= 2'h0;
         irq_request <= 1'b0;
      end else begin
         if (wr && paddr == subsystem_addr) begin
            irq_enable_q <= pwdata[irq_enable_lsb +: irq_count];
            soft_reset_sel <= pwdata[soft_reset_lsb +: 2];
         end
         irq_request <= |(irq_flags_q & irq_enable_q);
      end
   end

   // Command queue occupancy; the engine drains it by pulsing command_taken.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         queue_level_q <= queue_reset_level;
      end else begin
         queue_level_q <= queue_level_q + {3'h0, queue_push} - {3'h0, queue_pop};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         draw_command <= '0;
         draw_command_valid <= 1'b0;
         vector_first <= '0;
         vector_second <= '0;
         vector_valid <= 1'b0;
      end else begin
         draw_command_valid <= queue_push;
         vector_valid <= wr && (paddr == short_vector_addr);
         if (queue_push) begin
            draw_command <= draw_command_t'(pwdata[15:0]);
         end
         if (wr && paddr == short_vector_addr) begin
            vector_first <= short_vector_t'(pwdata[7:0]);
            vector_second <= short_vector_t'(pwdata[15:8]);
         end
      end
   end

   // Reserved upper bits are never stored, so they read back as zero whatever software wrote.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         advanced_function <= 16'h0000;
      end else if (wr_advanced_function) begin
         advanced_function <= pwdata[15:0] & afc_mask;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_y <= 12'h000;
      end else if (wr_current_y) begin
         current_y <= pwdata[11:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         current_x <= 12'h000;
      end else if (wr_current_x) begin
         current_x <= pwdata[11:0];
      end
   end

   // The destination words keep fourteen bits so that either meaning fits; the command decides which.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_y_step <= 14'h0000;
      end else if (wr_dest_y_step) begin
         dest_y_step <= pwdata[13:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_x_step <= 14'h0000;
      end else if (wr_dest_x_step) begin
         dest_x_step <= pwdata[13:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_error <= 14'h0000;
      end else if (wr_line_error) begin
         line_error <= pwdata[13:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         major_axis <= 12'h000;
      end else if (wr_major_axis) begin
         major_axis <= pwdata[11:0];
      end
   end

   // Colour and mask words are stored whole; none of their bits is reserved.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         background_colour <= 32'h0000_0000;
      end else if (wr_background_colour) begin
         background_colour <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         foreground_colour <= 32'h0000_0000;
      end else if (wr_foreground_colour) begin
         foreground_colour <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         plane_write_mask <= 32'h0000_0000;
      end else if (wr_plane_write_mask) begin
         plane_write_mask <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         plane_read_mask <= 32'h0000_0000;
      end else if (wr_plane_read_mask) begin
         plane_read_mask <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_colour <= 32'h0000_0000;
      end else if (wr_compare_colour) begin
         compare_colour <= pwdata;
      end
   end

   // Mix registers are write-only; the reserved bit between code and source is dropped on the way in.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         background_mix <= '0;
      end else if (wr_background_mix) begin
         background_mix <= mix_select_t'({pwdata[6:5], pwdata[3:0]});
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         foreground_mix <= '0;
      end else if (wr_foreground_mix) begin
         foreground_mix <= mix_select_t'({pwdata[6:5], pwdata[3:0]});
      end
   end

   // Read mux; write-only registers read as zero.
   always_comb begin
      rdata_d = 32'h0000_0000;
      unique case (paddr)
         system_config_addr: rdata_d[0] = enhanced_access_q;
         subsystem_addr: begin
            rdata_d[irq_count-1:0] = irq_flags_q;
            rdata_d[plane_count_bit] = eight_planes;
         end
         advanced_function_addr: rdata_d[15:0] = advanced_function;
         current_y_addr: rdata_d[11:0] = current_y;
         current_x_addr: rdata_d[11:0] = current_x;
         dest_y_step_addr: rdata_d[13:0] = dest_y_step;
         dest_x_step_addr: rdata_d[13:0] = dest_x_step;
         line_error_addr: rdata_d[13:0] = line_error;
         major_axis_addr: rdata_d[11:0] = major_axis;
         engine_cmd_addr: begin
            rdata_d[7:0] = free_slots[7:0];
            rdata_d[15:11] = free_slots[12:8];
            rdata_d[busy_bit] = engine_busy;
            rdata_d[all_empty_bit] = (queue_level_q == 4'h0);
         end
         background_colour_addr: rdata_d = background_colour;
         foreground_colour_addr: rdata_d = foreground_colour;
         plane_write_mask_addr: rdata_d = plane_write_mask;
         plane_read_mask_addr: rdata_d = plane_read_mask;
         compare_colour_addr: rdata_d = compare_colour;
         default: rdata_d = 32'h0000_0000;
      endcase
   end

endmodule // drawing_engine_command_regs

// >>> verilog/draw_regs_pkg.sv
// Package with the register map, field positions and types of the drawing engine command register bank.
package draw_regs_pkg;

   // Register byte addresses (all printed offsets are multiples of four).
   localparam logic [15:0] subsystem_addr = 16'h42e8;
   localparam logic [15:0] advanced_function_addr = 16'h4ae8;
   localparam logic [15:0] current_y_addr = 16'h82e8;
   localparam logic [15:0] current_x_addr = 16'h86e8;
   localparam logic [15:0] dest_y_step_addr = 16'h8ae8;
   localparam logic [15:0] dest_x_step_addr = 16'h8ee8;
   localparam logic [15:0] line_error_addr = 16'h92e8;
   localparam logic [15:0] major_axis_addr = 16'h96e8;
   localparam logic [15:0] engine_cmd_addr = 16'h9ae8;
   localparam logic [15:0] short_vector_addr = 16'h9ee8;
   localparam logic [15:0] background_colour_addr = 16'ha2e8;
   localparam logic [15:0] foreground_colour_addr = 16'ha6e8;
   localparam logic [15:0] plane_write_mask_addr = 16'haae8;
   localparam logic [15:0] plane_read_mask_addr = 16'haee8;
   localparam logic [15:0] compare_colour_addr = 16'hb2e8;
   localparam logic [15:0] background_mix_addr = 16'hb6e8;
   localparam logic [15:0] foreground_mix_addr = 16'hbae8;
   // System configuration register, holding the enhanced access enable in bit 0.
   localparam logic [15:0] system_config_addr = 16'h0040;

   // Field positions.
   localparam int irq_count = 4;
   localparam int irq_enable_lsb = 8;
   localparam int soft_reset_lsb = 14;
   localparam int plane_count_bit = 7;
   localparam int busy_bit = 9;
   localparam int all_empty_bit = 10;
   localparam int afc_enable_bit = 0;
   localparam int afc_4bpp_bit = 2;
   localparam int afc_linear_bit = 4;
   localparam logic [15:0] afc_mask = 16'h0015;
   localparam logic [15:0] coord_mask = 16'h0fff;
   localparam logic [15:0] step_mask = 16'h3fff;
   localparam logic [15:0] mix_mask = 16'h006f;

   // Interrupt sources in bit order.
   localparam int irq_vsync = 0;
   localparam int irq_busy = 1;
   localparam int irq_overflow = 2;
   localparam int irq_empty = 3;

   // Command queue.
   localparam int queue_depth = 8;
   localparam logic [12:0] queue_depth_slots = 13'h0008;
   localparam logic [3:0] queue_reset_level = 4'h0;

   typedef struct packed {
      logic [2:0] command_type;
      logic byte_swap;
      logic reserved;
      logic [1:0] bus_size;
      logic wait_host_data;
      logic [2:0] direction;
      logic draw_pixels;
      logic radial;
      logic last_pixel_off;
      logic across_plane;
      logic issue;
   } draw_command_t;

   typedef struct packed {
      logic [2:0] direction;
      logic draw_pixels;
      logic [3:0] length_m1;
   } short_vector_t;

   typedef struct packed {
      logic [1:0] colour_source;
      logic [3:0] mix_function;
   } mix_select_t;

endpackage

// >>> test/draw_regs_assertions.sv
// Concurrent checks on the ports of the drawing engine register bank.
`timescale 1ns/1ps
module draw_regs_assertions
   import draw_regs_pkg::*;
(
   // Clock, reset and APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Engine controls
   input wire logic [1:0] soft_reset_sel,
   input wire logic [15:0] advanced_function,
   input wire logic [11:0] current_x,
   input wire logic draw_command_valid,
   input wire short_vector_t vector_first,
   input wire short_vector_t vector_second,
   input wire logic vector_valid
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wr(logic [15:0] a);
      psel && penable && pwrite && pready && !pslverr && paddr == a;
   endsequence
   a_ready_after_setup: assert property (psel && !penable |=> pready)
      else $error("no pready after setup");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_idle_data_zero: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside access");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_afc_reserved: assert property ((advanced_function & ~afc_mask) == 16'h0)
      else $error("reserved control bit stored");
   a_coord_store: assert property (s_wr(current_x_addr) |=> current_x == $past(pwdata[11:0]))
      else $error("coordinate not stored");
   a_reset_select: assert property (s_wr(subsystem_addr) |=> soft_reset_sel == $past(pwdata[15:14]))
      else $error("reset selection not stored");
   a_cmd_cause: assert property (draw_command_valid |->
      $past(pwrite && pready && paddr == engine_cmd_addr) ##1 !draw_command_valid)
      else $error("command pulse without write");
   a_vector_split: assert property (vector_valid |->
      vector_first == $past(pwdata[7:0]) && vector_second == $past(pwdata[15:8]))
      else $error("vector bytes misplaced");
endmodule // draw_regs_assertions
bind drawing_engine_command_regs draw_regs_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .soft_reset_sel, .advanced_function, .current_x, .draw_command_valid,
   .vector_first, .vector_second, .vector_valid);

// >>> test/engine_model.sv
// Behavioural drawing engine that consumes queued commands and raises events.
`timescale 1ns/1ps
module engine_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bank output and bench controls
   input wire logic draw_command_valid,
   input wire logic drain,
   input wire logic vsync_req,
   input wire logic planes_req,
   // Events toward the bank
   output logic vsync_event,
   output logic engine_busy,
   output logic command_taken,
   output logic eight_planes
);
   logic [3:0] pending_q;
   logic take;
   // Takes are two cycles apart so the bank's level settles between pops.
   assign take = drain && !command_taken && pending_q != 4'h0;
   assign engine_busy = pending_q != 4'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pending_q <= 4'h0;
         command_taken <= 1'b0;
      end else begin
         pending_q <= pending_q + {3'h0, draw_command_valid} - {3'h0, take};
         command_taken <= take;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vsync_event <= 1'b0;
         eight_planes <= 1'b0;
      end else begin
         vsync_event <= vsync_req;
         eight_planes <= planes_req;
      end
   end
endmodule // engine_model

// >>> test/drawing_engine_command_regs_tb.sv
// Self-checking testbench of the drawing engine register bank.
`timescale 1ns/1ps
module drawing_engine_command_regs_tb;
   import draw_regs_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
   logic drain = 1'b0, vsync_req = 1'b0, planes_req = 1'b0, vsync_event, engine_busy, command_taken, eight_planes;
   logic irq_request, draw_command_valid, vector_valid;
   logic [15:0] paddr = 16'h0, advanced_function;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, background_colour, foreground_colour, plane_write_mask;
   logic [31:0] plane_read_mask, compare_colour;
   logic [1:0] soft_reset_sel;
   logic [11:0] current_y, current_x, major_axis;
   logic [13:0] dest_y_step, dest_x_step, line_error;
   draw_command_t draw_command;
   short_vector_t vector_first, vector_second;
   mix_select_t background_mix, foreground_mix;
   int bad_count = 0, checked = 0;
   localparam logic [15:0] rw_addr [12] = '{advanced_function_addr, current_y_addr, current_x_addr,
      dest_y_step_addr, dest_x_step_addr, line_error_addr, major_axis_addr, background_colour_addr,
      foreground_colour_addr, plane_write_mask_addr, plane_read_mask_addr, compare_colour_addr};
   localparam logic [31:0] rw_mask [12] = '{32'h15, 32'hfff, 32'hfff, 32'h3fff, 32'h3fff, 32'h3fff, 32'hfff,
      '1, '1, '1, '1, '1};
   always #50 pclk = ~pclk;
   drawing_engine_command_regs DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .vsync_event, .engine_busy, .command_taken, .eight_planes, .irq_request, .soft_reset_sel,
      .advanced_function, .current_y, .current_x, .dest_y_step, .dest_x_step, .line_error, .major_axis,
      .draw_command, .draw_command_valid, .vector_first, .vector_second, .vector_valid, .background_colour,
      .foreground_colour, .plane_write_mask, .plane_read_mask, .compare_colour, .background_mix, .foreground_mix);
   engine_model partner (.pclk, .presetn, .draw_command_valid, .drain, .vsync_req, .planes_req, .vsync_event,
      .engine_busy, .command_taken, .eight_planes);
   task automatic final_report();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One idle edge before each setup keeps psel from being driven twice in a time step.
   task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for pready that never comes.
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      #1;
   endtask
   function automatic logic [31:0] slots_exp(input int lvl);
      logic [12:0] f;
      f = 13'(queue_depth - lvl);
      return {16'h0, f[12:8], lvl == 0, lvl != 0, 1'b0, f[7:0]};
   endfunction
   function automatic logic [31:0] port_of(input logic [15:0] a);
      case (a)
         advanced_function_addr: return {16'h0, advanced_function};
         current_y_addr: return {20'h0, current_y};
         current_x_addr: return {20'h0, current_x};
         dest_y_step_addr: return {18'h0, dest_y_step};
         dest_x_step_addr: return {18'h0, dest_x_step};
         line_error_addr: return {18'h0, line_error};
         major_axis_addr: return {20'h0, major_axis};
         background_colour_addr: return background_colour;
         foreground_colour_addr: return foreground_colour;
         plane_write_mask_addr: return plane_write_mask;
         plane_read_mask_addr: return plane_read_mask;
         compare_colour_addr: return compare_colour;
         default: return 32'h0;
      endcase
   endfunction
   initial begin
      #500000;
      bad_count++;
      final_report();
   end
   initial begin
      void'($urandom(32'h2d6e5475));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, current_x_addr, 32'h0123);
      apb(1'b0, current_x_addr, 32'h0);
      chk("closed error", 32'h1, {31'h0, err});
      apb(1'b1, system_config_addr, 32'h1);
      apb(1'b0, current_x_addr, 32'h0);
      chk("closed write", 32'h0, rd);
      apb(1'b0, 16'h1234, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      for (int i = 0; i < 36; i++) begin
         v = (i < 12) ? '1 : $urandom();
         apb(1'b1, rw_addr[i % 12], v);
         chk("port", v & rw_mask[i % 12], port_of(rw_addr[i % 12]));
         apb(1'b0, rw_addr[i % 12], 32'h0);
         chk("readback", v & rw_mask[i % 12], rd);
      end
      for (int k = 1; k <= 9; k++) begin
         v = $urandom() | 32'h1;
         apb(1'b1, engine_cmd_addr, v);
         if (k < 9) chk("command", {16'h0, v[15:0]}, {16'h0, draw_command});
         apb(1'b0, engine_cmd_addr, 32'h0);
         chk("slots", slots_exp(k < 9 ? k : 8), rd);
      end
      apb(1'b0, subsystem_addr, 32'h0);
      chk("flags full", 32'h6, rd);
      @(posedge pclk);
      drain <= 1'b1;
      for (int i = 0; i < 30 && rd[10] !== 1'b1; i++) apb(1'b0, engine_cmd_addr, 32'h0);
      chk("drained", slots_exp(0), rd);
      @(posedge pclk);
      vsync_req <= 1'b1;
      planes_req <= 1'b1;
      @(posedge pclk);
      vsync_req <= 1'b0;
      apb(1'b0, subsystem_addr, 32'h0);
      chk("flags all", 32'h8f, rd);
      apb(1'b1, subsystem_addr, 32'h0100);
      @(posedge pclk);
      #1;
      chk("irq raised", 32'h1, {31'h0, irq_request});
      apb(1'b1, subsystem_addr, 32'h0e0e);
      @(posedge pclk);
      #1;
      chk("irq masked", 32'h0, {31'h0, irq_request});
      apb(1'b0, subsystem_addr, 32'h0);
      chk("flags cleared", 32'h81, rd);
      apb(1'b1, subsystem_addr, 32'hc001);
      chk("reset select", 32'h3, {30'h0, soft_reset_sel});
      apb(1'b0, subsystem_addr, 32'h0);
      chk("vsync cleared", 32'h80, rd);
      v = $urandom();
      apb(1'b1, short_vector_addr, v);
      chk("vectors", {16'h0, v[15:0]}, {16'h0, vector_second, vector_first});
      apb(1'b1, background_mix_addr, v);
      chk("background mix", {26'h0, v[6:5], v[3:0]}, {26'h0, background_mix});
      apb(1'b1, foreground_mix_addr, ~v);
      chk("foreground mix", {26'h0, ~v[6:5], ~v[3:0]}, {26'h0, foreground_mix});
      // A reset in mid-run must clear what was stored and close the bank again.
      @(posedge pclk);
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      #1;
      chk("reset colour", 32'h0, background_colour);
      chk("reset command", 32'h0, {16'h0, draw_command});
      apb(1'b0, current_x_addr, 32'h0);
      chk("reset closes bank", 32'h1, {31'h0, err});
      final_report();
   end
endmodule // drawing_engine_command_regs_tb
